// *** design/latency_timer.sv ***
// counts link clock edges from select low to find command and data phases
`timescale 1ns/1ns
`default_nettype none
`include "psram_cfg_consts.svh"
module latency_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // transaction framing
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic       tick,
  input  wire logic [4:0] target,
  // phase indication
  output logic            running,
  output logic            ca_phase,
  output logic            data_phase,
  output logic      [4:0] cnt
);
  logic [4:0] cnt_q;
  logic       run_q;

  // saturating edge counter, cleared at each start unless stop comes in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      run_q <= 1'b0;
    end else if (stop) begin
      run_q <= 1'b0;
    end else if (start) begin
      run_q <= 1'b1;
      cnt_q <= 5'h00;
    end else if (run_q && tick && cnt_q != 5'h1F) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // phases follow from the count, the run flag and the target
  assign running    = run_q;
  assign cnt        = cnt_q;
  assign ca_phase   = run_q && (cnt_q < `CA_CLOCKS);
  assign data_phase = run_q && (cnt_q >= 5'(`CA_CLOCKS + target));
endmodule : latency_timer
`default_nettype wire

// *** design/psram_cfg_consts.svh ***
// offsets, field positions, reset values and timing counts of the config bank
`ifndef PSRAM_CFG_CONSTS_SVH
`define PSRAM_CFG_CONSTS_SVH
// apb byte offsets
`define OFF_LAT_PWR     12'h000
`define OFF_REF_SLEEP   12'h004
`define OFF_STATUS      12'h008
// latency_power_config fields
`define PD_BIT          15
`define DRV_HI          14
`define DRV_LO          12
`define LAT_HI          7
`define LAT_LO          4
`define FIX_BIT         3
`define BURST_HI        2
// refresh_sleep_config fields
`define CKT_BIT         6
`define HS_BIT          5
`define PAR_HI          4
`define PAR_LO          2
// reset values
`define LAT_RST         4'h7
`define DRV_RST         3'h0
`define BURST_RST       3'h4
`define PAR_RST         3'h0
`define CFG1_RSVD_HI    8'hFF
// latency limits and codes
`define LAT_MIN         4'h3
`define LAT_MAX         4'h7
`define PAR_NONE        3'h4
`define CA_CLOCKS       5'h03
// timing
`define SYS_CLK_MHZ     100
`define PD_ENTRY_NS     1000
`endif

// *** design/psram_cfg_pkg.sv ***
// types shared by the latency and power configuration bank
`default_nettype none
package psram_cfg_pkg;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_ENTER,
    PWR_DPD
  } pwr_t;
endpackage : psram_cfg_pkg
`default_nettype wire

// *** design/psram_latency_config_regs.sv ***
// latency, strobe and power configuration bank with apb register access
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "psram_cfg_consts.svh"
module psram_latency_config_regs (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // memory bus pins, asynchronous
  input  wire logic        select_n,
  input  wire logic        link_clk,
  input  wire logic        complementary_clock,
  input  wire logic        ca_read,
  input  wire logic        ca_reg_space,
  input  wire logic        hw_reset_n,
  // strobe line drive
  output logic             strobe_line_o,
  output logic             strobe_line_oe,
  // internal refresh engine, same clock
  input  wire logic        refresh_pending,
  input  wire logic [1:0]  refresh_interval,
  output logic             refresh_enable,
  output logic             refresh_allow,
  output logic      [2:0]  refresh_part,
  // pad and phase control
  output logic      [2:0]  drive_strength,
  output logic             ckn_enable,
  output logic             data_phase,
  output logic             deep_power_down,
  output logic             hybrid_sleep
);
  localparam int PD_CYC = (`PD_ENTRY_NS * `SYS_CLK_MHZ + 999) / 1000;

  psram_cfg_pkg::pwr_t pwr_q;
  logic [6:0]  pd_cnt_q;
  logic        pd_q, fix_q, ck_single_q, hs_q;
  logic [3:0]  lat_q;
  logic [2:0]  drv_q, burst_q, par_q;
  logic        cs_prev_q, ck_prev_q, regw_q, extra_q;
  logic        strobe_q, strobe_oe_q, data_q, ref_en_q, ref_ok_q, ckn_en_q, dpd_q, pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        cs_s, ck_s, ckn_s, rw_s, reg_s, hwrst_s;
  logic        t_run, t_ca, t_data;
  logic [4:0]  t_cnt;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, select and reset idle high
  sync2 #(.W(6), .INIT(6'h21)) u_pins (
    .clk   (sys_clk),
    .rst_n (nrst),
    .d     ({select_n, link_clk, complementary_clock, ca_read, ca_reg_space, hw_reset_n}),
    .q     ({cs_s, ck_s, ckn_s, rw_s, reg_s, hwrst_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire in_dpd   = (pwr_q == psram_cfg_pkg::PWR_DPD);
  wire cfg_rst  = !hwrst_s;
  wire cs_fall  = cs_prev_q && !cs_s;
  wire cs_rise  = !cs_prev_q && cs_s;
  // single-ended mode never looks at the complementary clock
  wire tick     = ck_s && !ck_prev_q && (ck_single_q || !ckn_s);
  wire tx_start = cs_fall && !in_dpd;
  wire acc      = psel && penable;
  wire sel0     = (paddr == `OFF_LAT_PWR);
  wire sel1     = (paddr == `OFF_REF_SLEEP);
  wire sel2     = (paddr == `OFF_STATUS);
  wire wr_en    = acc && pwrite && !in_dpd;
  wire wr0      = wr_en && sel0;
  wire wr1      = wr_en && sel1;
  wire [3:0] lat_code = pwdata[`LAT_HI:`LAT_LO];
  wire lat_ok   = (lat_code >= `LAT_MIN) && (lat_code <= `LAT_MAX);
  wire pd_wr0   = wr0 && !pwdata[`PD_BIT];
  wire dpd_exit = in_dpd && cs_rise;
  // register write: no latency; else one or two periods
  wire [4:0] tgt = regw_q ? 5'h00 : (extra_q ? {lat_q, 1'b0} : {1'b0, lat_q});
  wire [15:0] cfg0_rd = {pd_q, drv_q, 4'h0, lat_q, fix_q, burst_q};
  // upper byte and bit 7 always read as ones
  wire [15:0] cfg1_rd = {`CFG1_RSVD_HI, 1'b1, ck_single_q, hs_q, par_q, refresh_interval};
  wire [31:0] stat_rd = {25'h0, in_dpd, hs_q, refresh_pending, extra_q, regw_q, t_run, data_q};
  wire [31:0] rd_mux  = sel0 ? {16'h0, cfg0_rd} : sel1 ? {16'h0, cfg1_rd} :
                        sel2 ? stat_rd : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  // edge history of synchronised select and link clock
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_prev_q <= 1'b1;
      ck_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      ck_prev_q <= ck_s;
    end
  end

  // apb: zero wait, data captured in setup so it is stable in access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b1;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h0 : rd_mux;
      pslverr_q <= !(sel0 || sel1 || sel2);
    end
  end

  // latency_power_config; hardware reset pin restores defaults
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lat_q   <= `LAT_RST;
      fix_q   <= 1'b1;
      drv_q   <= `DRV_RST;
      burst_q <= `BURST_RST;
      pd_q    <= 1'b1;
    end else if (cfg_rst) begin
      lat_q   <= `LAT_RST;
      fix_q   <= 1'b1;
      drv_q   <= `DRV_RST;
      burst_q <= `BURST_RST;
      pd_q    <= 1'b1;
    end else begin
      if (wr0) begin
        if (lat_ok) begin
          lat_q <= lat_code;
        end
        fix_q   <= pwdata[`FIX_BIT];
        drv_q   <= pwdata[`DRV_HI:`DRV_LO];
        burst_q <= pwdata[`BURST_HI:0];
        pd_q    <= pwdata[`PD_BIT];
      end
      if (dpd_exit) begin
        pd_q <= 1'b1;
      end
    end
  end

  // refresh_sleep_config; upper bits are not stored, writes ignored there
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ck_single_q <= 1'b1;
      hs_q        <= 1'b0;
      par_q       <= `PAR_RST;
    end else if (cfg_rst) begin
      ck_single_q <= 1'b1;
      hs_q        <= 1'b0;
      par_q       <= `PAR_RST;
    end else if (wr1) begin
      ck_single_q <= pwdata[`CKT_BIT];
      hs_q        <= pwdata[`HS_BIT];
      par_q       <= pwdata[`PAR_HI:`PAR_LO];
    end else if (cs_fall) begin
      hs_q        <= 1'b0;
    end
  end

  // power state: entry delay, then only select rising or the hardware reset pin can wake it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_q    <= psram_cfg_pkg::PWR_RUN;
      pd_cnt_q <= 7'h00;
    end else if (cfg_rst) begin
      pwr_q    <= psram_cfg_pkg::PWR_RUN;
    end else begin
      unique case (pwr_q)
        psram_cfg_pkg::PWR_RUN: begin
          if (pd_wr0) begin
            pwr_q    <= psram_cfg_pkg::PWR_ENTER;
            pd_cnt_q <= 7'(PD_CYC - 1);
          end
        end
        psram_cfg_pkg::PWR_ENTER: begin
          if (pd_cnt_q == 7'h00) begin
            pwr_q <= psram_cfg_pkg::PWR_DPD;
          end else begin
            pd_cnt_q <= pd_cnt_q - 7'h01;
          end
        end
        psram_cfg_pkg::PWR_DPD: begin
          if (cs_rise) begin
            pwr_q <= psram_cfg_pkg::PWR_RUN;
          end
        end
      endcase
    end
  end

  // transaction kind and latency decision, taken at select low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regw_q  <= 1'b0;
      extra_q <= 1'b0;
    end else if (tx_start) begin
      regw_q  <= reg_s && !rw_s;
      extra_q <= fix_q || refresh_pending;
    end
  end

  latency_timer u_timer (
    .clk        (sys_clk),
    .rst_n      (nrst),
    .start      (tx_start),
    .stop       (cs_rise || cfg_rst),
    .tick       (tick),
    .target     (tgt),
    .running    (t_run),
    .ca_phase   (t_ca),
    .data_phase (t_data),
    .cnt        (t_cnt)
  );

  // registered pin and engine controls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_q    <= 1'b0;
      strobe_oe_q <= 1'b0;
      data_q      <= 1'b0;
      ref_en_q    <= 1'b1;
      ref_ok_q    <= 1'b1;
      ckn_en_q    <= 1'b0;
      dpd_q       <= 1'b0;
    end else begin
      strobe_oe_q <= t_ca && !in_dpd;
      strobe_q    <= t_ca && extra_q;
      data_q      <= t_data && !t_ca;
      // power-down and the none setting both halt refresh
      ref_en_q    <= !in_dpd && (par_q != `PAR_NONE);
      // register writes do not block refresh, unlike memory access
      ref_ok_q    <= !t_run || regw_q;
      ckn_en_q    <= !ck_single_q;
      dpd_q       <= in_dpd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign strobe_line_o   = strobe_q;
  assign strobe_line_oe  = strobe_oe_q;
  assign refresh_enable  = ref_en_q;
  assign refresh_allow   = ref_ok_q;
  assign refresh_part    = par_q;
  assign drive_strength  = drv_q;
  assign ckn_enable      = ckn_en_q;
  assign data_phase      = data_q;
  assign deep_power_down = dpd_q;
  assign hybrid_sleep    = hs_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence pd_request_s;
    pd_wr0 && pwr_q == psram_cfg_pkg::PWR_RUN;
  endsequence
  sequence asleep_s;
    in_dpd ##1 in_dpd;
  endsequence

  lat_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    lat_q >= `LAT_MIN && lat_q <= `LAT_MAX) else $error("latency out of range");
  lat_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr0 && !lat_ok && !cfg_rst |=> lat_q == $past(lat_q)) else $error("reserved code taken");
  fixed_strobe_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    tx_start && fix_q |=> extra_q) else $error("fixed latency not signalled");
  ca_strobe_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    t_ca && !in_dpd |=> strobe_line_oe && strobe_line_o == $past(extra_q))
    else $error("strobe wrong in command phase");
  regw_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(t_ca) && t_run && regw_q |-> t_data) else $error("register write delayed");
  lat_double_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(t_data) && !t_ca && !regw_q |-> t_cnt == 5'(`CA_CLOCKS + (extra_q ? 2 : 1) * lat_q))
    else $error("data phase at wrong count");
  dpd_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pd_request_s ##1 !cfg_rst [*8] |-> ##[1:100] in_dpd) else $error("power-down not entered");
  dpd_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    asleep_s |=> !strobe_line_oe && !refresh_enable) else $error("activity in power-down");
  dpd_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    in_dpd && cs_rise && !cfg_rst |=> !in_dpd && pd_q) else $error("power-down exit missed");
  hs_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cs_fall && !wr1 |=> !hybrid_sleep) else $error("hybrid sleep not cleared");
endmodule : psram_latency_config_regs
`default_nettype wire

// *** design/sync2.sv ***
// two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // meta_q feeds only q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sync2
`default_nettype wire

// *** dv/host_link_model.sv ***
// host-side model of the memory link: select, link clock and transaction kind
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  // clock
  input  wire logic sys_clk,
  // pins driven toward the device
  output logic      select_n,
  output logic      link_clk,
  output logic      complementary_clock,
  output logic      ca_read,
  output logic      ca_reg_space,
  // device outputs watched
  input  wire logic data_phase,
  input  wire logic strobe_line_o,
  input  wire logic strobe_line_oe,
  input  wire logic refresh_allow
);
  logic oe_q, st_q, drop_q, run_q, clr_q;

  // idle bus: deselected, link clock parked low
  initial begin
    select_n = 1'b1;
    link_clk = 1'b0;
    complementary_clock = 1'b1;
    ca_read = 1'b0;
    ca_reg_space = 1'b0;
    run_q = 1'b0;
    clr_q = 1'b0;
  end

  // strobe level and refresh hold-off seen during a frame; only this process owns them
  always @(posedge sys_clk) begin
    if (clr_q) begin
      oe_q   <= 1'b0;
      st_q   <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      if (strobe_line_oe === 1'b1) begin
        oe_q <= 1'b1;
        st_q <= st_q | strobe_line_o;
      end
      if (run_q && refresh_allow !== 1'b1) begin
        drop_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////
  // one frame; counts link rises until the data window opens, seen = {drop, strobe, oe}
  task automatic frame(input logic rd, input logic rs, input logic df,
                       output logic [7:0] edges, output logic [2:0] seen);
    edges = 8'h00;
    @(posedge sys_clk);
    ca_read      <= rd;
    ca_reg_space <= rs;
    clr_q        <= 1'b1;
    @(posedge sys_clk);
    clr_q        <= 1'b0;
    repeat (2) @(posedge sys_clk);
    select_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    run_q <= 1'b1;
    // bounded, select never stays low past its limit
    for (int i = 1; i <= 24 && edges == 8'h00; i++) begin
      link_clk            <= 1'b1;
      complementary_clock <= !df;
      repeat (4) @(posedge sys_clk);
      link_clk            <= 1'b0;
      complementary_clock <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (data_phase === 1'b1) begin
        edges = 8'(i);
      end
    end
    run_q        <= 1'b0;
    select_n     <= 1'b1; // low then high also wakes from power-down
    ca_read      <= !rd;
    ca_reg_space <= !rs;
    repeat (8) @(posedge sys_clk);
    seen = {drop_q, st_q, oe_q};
  endtask : frame
endmodule : host_link_model
`default_nettype wire

// *** dv/test_psram_latency_config_regs.sv ***
// self-checking bench for the latency, strobe and power configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "psram_cfg_consts.svh"
module test_psram_latency_config_regs;
  logic        sys_clk, nrst, psel, penable, pwrite, hw_reset_n, refresh_pending, pend;
  logic        pready, pslverr, select_n, link_clk, complementary_clock, ca_read;
  logic        ca_reg_space, strobe_line_o, strobe_line_oe, refresh_enable, refresh_allow;
  logic        ckn_enable, data_phase, deep_power_down, hybrid_sleep, slv_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [1:0]  refresh_interval;
  logic [2:0]  refresh_part, drive_strength;
  logic [15:0] c0, w;
  logic [3:0]  lat;
  int          num_errors = 0;
  int          tests_run = 0;

  psram_latency_config_regs psram_latency_config_regs_inst (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_n(select_n), .link_clk(link_clk), .complementary_clock(complementary_clock),
    .ca_read(ca_read), .ca_reg_space(ca_reg_space), .hw_reset_n(hw_reset_n),
    .strobe_line_o(strobe_line_o), .strobe_line_oe(strobe_line_oe),
    .refresh_pending(refresh_pending), .refresh_interval(refresh_interval),
    .refresh_enable(refresh_enable), .refresh_allow(refresh_allow),
    .refresh_part(refresh_part), .drive_strength(drive_strength), .ckn_enable(ckn_enable),
    .data_phase(data_phase), .deep_power_down(deep_power_down), .hybrid_sleep(hybrid_sleep));

  host_link_model host_link_model_inst (
    .sys_clk(sys_clk), .select_n(select_n), .link_clk(link_clk),
    .complementary_clock(complementary_clock), .ca_read(ca_read),
    .ca_reg_space(ca_reg_space), .data_phase(data_phase), .strobe_line_o(strobe_line_o),
    .strobe_line_oe(strobe_line_oe), .refresh_allow(refresh_allow));

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  //////////////////////////////////////////////////
  // xorshift keeps every run identical
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // link rises up to the data window; doubled latency when strobe was high
  function automatic logic [31:0] exp_edges(input logic rw, input logic ex, input logic [3:0] l);
    return rw ? 32'h3 : 32'h3 + (ex ? 32'(l) * 2 : 32'(l));
  endfunction : exp_edges

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  //////////////////////////////////////////////////
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wn, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rv, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wn;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rv;
    logic        er;
    apb(1'b1, a, d, rv, er);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rv;
    logic        er;
    apb(1'b0, a, 32'h0, rv, er);
    chk(rv, exp);
    chk(32'(er), 32'h0);
  endtask : rchk

  // one link transaction checked against latency, strobe and refresh hold-off
  task automatic do_frame(input logic rd, input logic rs, input logic df, input logic pd);
    logic [7:0] ed;
    logic [2:0] sn;
    logic       rw;
    logic       ex;
    rw = !rd && rs;
    ex = c0[3] | pend;
    host_link_model_inst.frame(rd, rs, df, ed, sn);
    if (pd) begin
      chk(32'({ed, sn[0]}), 32'h0);
    end else begin
      chk(32'(ed), exp_edges(rw, ex, c0[7:4]));
      chk(32'({sn[2], sn[0]}), 32'({!rw, 1'b1}));
      if (!rw) begin
        chk(32'(sn[1]), 32'(ex));
      end
      if (ed == 8'h00) begin
        give_verdict();
      end
    end
  endtask : do_frame

  //////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hw_reset_n = 1'b1;
    refresh_pending = 1'b0;
    pend = 1'b0;
    seed = 32'h00002A77;
    r = rnd();
    refresh_interval = r[1:0];
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    c0 = 16'h807C;
    rchk(`OFF_LAT_PWR, 32'h0000807C);
    rchk(`OFF_REF_SLEEP, {16'h0, 14'h3FF0, refresh_interval});
    chk({26'h0, drive_strength, ckn_enable, hybrid_sleep, deep_power_down}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      pend = r[0];
      refresh_pending <= pend;
      do_frame(k[0], k[1], 1'b0, 1'b0);
    end
    $display("done: reset defaults and default latency");
    // random latency, drive and fixed settings, boundary codes 2, 3, 8 and 7 first
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      lat = (i < 4) ? 4'(16'h7832 >> (4 * i)) : r[7:4];
      w = {1'b1, r[14:8], lat, r[3:0]};
      wr(`OFF_LAT_PWR, {16'h0, w});
      c0 = {w[15:12], 4'h0, (lat >= 4'h3 && lat <= 4'h7) ? lat : c0[7:4], w[3:0]};
      rchk(`OFF_LAT_PWR, {16'h0, c0});
      chk(32'(drive_strength), 32'(c0[14:12]));
      pend = r[16];
      refresh_pending <= pend;
      do_frame(r[17], r[18], 1'b0, 1'b0);
    end
    $display("done: latency settings");
    apb(1'b1, 12'hFFC, 32'h0000FFFF, r, slv_err);
    chk(32'(slv_err), 32'h1); // unmapped write answers with an error
    apb(1'b0, 12'hFFC, 32'h0, r, slv_err);
    chk(r, 32'h0); // unmapped read gives zero
    chk(32'(slv_err), 32'h1); // unmapped read answers with an error
    rchk(`OFF_LAT_PWR, {16'h0, c0});
    $display("done: unmapped access");
    // every partial refresh code, clock type alternating
    for (int p = 0; p < 8; p++) begin
      w = {8'hFF, 1'b1, p[0], 1'b0, p[2:0], 2'b11};
      wr(`OFF_REF_SLEEP, {16'h0, w});
      // registered enables follow the stored field one edge later
      @(posedge sys_clk);
      chk({27'h0, refresh_part, refresh_enable, ckn_enable}, {27'h0, p[2:0], p != 4, !p[0]});
      rchk(`OFF_REF_SLEEP, {16'h0, w[15:2], refresh_interval});
      if (!p[0]) begin
        do_frame(1'b1, 1'b0, 1'b1, 1'b0);
      end
    end
    $display("done: refresh and clock type");
    wr(`OFF_REF_SLEEP, 32'h0000FFE0);
    chk(32'(hybrid_sleep), 32'h1);
    do_frame(1'b1, 1'b1, 1'b0, 1'b0);
    chk(32'(hybrid_sleep), 32'h0);
    rchk(`OFF_REF_SLEEP, {16'h0, 14'h3FF0, refresh_interval});
    $display("done: hybrid sleep");
    wr(`OFF_LAT_PWR, {16'h0, c0 & 16'h7FFF});
    repeat (110) @(posedge sys_clk);
    chk({30'h0, deep_power_down, refresh_enable}, 32'h2);
    wr(`OFF_LAT_PWR, 32'h0000C03C);
    do_frame(1'b1, 1'b0, 1'b0, 1'b1);
    chk(32'(deep_power_down), 32'h0);
    rchk(`OFF_LAT_PWR, {16'h0, c0});
    $display("done: deep power-down");
    wr(`OFF_REF_SLEEP, 32'h0000FFE0);
    wr(`OFF_LAT_PWR, 32'h0000A034);
    hw_reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    c0 = 16'h807C;
    chk(32'(hybrid_sleep), 32'h0);
    rchk(`OFF_LAT_PWR, 32'h0000807C);
    pend = 1'b0;
    refresh_pending <= pend;
    do_frame(1'b0, 1'b0, 1'b0, 1'b0);
    $display("done: hardware reset");
    give_verdict();
  end
endmodule : test_psram_latency_config_regs
`default_nettype wire
